// ===== accel_regs.vh
// Register offsets, field positions, reset values and link codes for the accelerometer register bank.
`ifndef ACCEL_REGS_VH
`define ACCEL_REGS_VH
`define ADDR_SAMPLE_STATUS  7'h00
`define ADDR_X_HIGH         7'h01
`define ADDR_X_LOW          7'h02
`define ADDR_Y_HIGH         7'h03
`define ADDR_Y_LOW          7'h04
`define ADDR_Z_HIGH         7'h05
`define ADDR_Z_LOW          7'h06
`define ADDR_FIFO_SETUP     7'h09
`define ADDR_ID_LINK        7'h0D
`define ADDR_JOLT_THRESHOLD 7'h1F
`define ADDR_JOLT_DEBOUNCE  7'h20
`define ADDR_TAP_CONFIG     7'h21
`define ADDR_TAP_SOURCE     7'h22
`define ADDR_TAP_THR_X      7'h23
`define ADDR_TAP_THR_Y      7'h24
`define ADDR_TAP_THR_Z      7'h25
`define ADDR_TAP_TIME_LIMIT 7'h26
`define ADDR_TAP_LATENCY    7'h27
`define ADDR_TAP_WINDOW     7'h28
`define ADDR_SLEEP_COUNTER  7'h29
`define ADDR_CONTROL_ONE    7'h2A
`define ADDR_CONTROL_TWO    7'h2B
`define ADDR_CONTROL_THREE  7'h2C
`define ADDR_IRQ_ENABLE     7'h2D
`define ADDR_IRQ_PIN_MAP    7'h2E
`define ADDR_X_OFFSET       7'h2F
`define ADDR_Y_OFFSET       7'h30
`define ADDR_Z_OFFSET       7'h31
`define ADDR_RESERVED_BASE  7'h40
`define RESET_BYTE          8'h00
`define BIT_ACTIVE          0
`define BIT_FAST_READ       1
`define BIT_SOFT_RESET      6
`define BIT_FIFO_MODE_HI    7
`define BIT_FIFO_MODE_LO    6
`define DEBOUNCE_JOLT       2'h0
`define DEBOUNCE_TAP_X      2'h1
`define DEBOUNCE_TAP_Y      2'h2
`endif

// ===== accel_regs_checker.sv
// Assertions on the ports of the accelerometer register bank.
`timescale 1ns/1ps
module accel_regs_checker #(
   parameter WIDTH = 14
) (
   // Clock and reset
   input wire             clk,
   input wire             srst,
   // Register access
   input wire             addr_load,
   input wire [6:0]       addr_value,
   input wire             wr_en,
   input wire [7:0]       wr_data,
   input wire             rd_en,
   input wire             bus_stop,
   input wire [7:0]       rd_data,
   // FIFO side and configuration
   input wire [WIDTH-1:0] fifo_x,
   input wire [WIDTH-1:0] fifo_y,
   input wire [7:0]       fifo_status,
   input wire [7:0]       fifo_setup,
   input wire [7:0]       control_one,
   input wire [7:0]       control_two,
   input wire             tap_z_restart,
   input wire [2:0]       debounce_restart
);
   wire idle    = !(addr_load || bus_stop || rd_en || wr_en);
   wire fifo_on = fifo_setup[7:6] != 2'h0;
   wire rd_only = rd_en && !addr_load && !bus_stop;
   wire no_srst = !(wr_en && wr_data[6]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Pointer load, one quiet cycle, then a read.
   sequence s_rd_at(hit);
      addr_load && !bus_stop && hit ##1 idle ##1 rd_only;
   endsequence

   a_read_hold: assert property (!rd_en |=> rd_data == $past(rd_data))
      else $error("read data changed with no read");
   a_reserved_zero: assert property (s_rd_at(addr_value[6]) |=> rd_data == 8'h00)
      else $error("reserved address read not zero");
   a_fifo_status: assert property (s_rd_at(addr_value == 7'h00) ##0 fifo_on |=> rd_data == $past(fifo_status))
      else $error("status address did not show FIFO status");
   a_fifo_head: assert property (s_rd_at(addr_value == 7'h01) ##0 fifo_on |=> rd_data == $past(fifo_x[WIDTH-1:WIDTH-8]))
      else $error("X high byte did not show FIFO head");
   a_fast_skip: assert property (s_rd_at(addr_value == 7'h01) ##0 (fifo_on && control_one[1]) ##1 idle ##1 rd_only
      |=> rd_data == $past(fifo_y[WIDTH-1:WIDTH-8]))
      else $error("fast read did not skip the low byte");
   a_stop_clears: assert property (bus_stop ##1 idle ##1 (rd_only && fifo_on) |=> rd_data == $past(fifo_status))
      else $error("stop did not clear the pointer");
   a_cfg_frozen: assert property (control_one[0] && no_srst |=> control_one[7:1] == $past(control_one[7:1]))
      else $error("control bits changed while active");
   a_fifo_frozen: assert property (control_one[0] && no_srst |=> $stable(fifo_setup))
      else $error("FIFO setup changed while active");
   a_two_frozen: assert property (control_one[0] && no_srst |=> $stable(control_two))
      else $error("control two changed while active");
   a_tap_z_gate: assert property (tap_z_restart |-> $past(wr_en && !control_one[0]))
      else $error("Z tap restart outside a standby write");
   a_jolt_restart: assert property (addr_load && !bus_stop && addr_value == 7'h20 ##1 idle ##1 (wr_en && !addr_load && !bus_stop)
      |=> debounce_restart == 3'h1)
      else $error("debounce restart missing after count write");
endmodule

bind accel_status_data_regs accel_regs_checker #(.WIDTH(WIDTH)) u_chk (
   .clk(clk), .srst(srst), .addr_load(addr_load), .addr_value(addr_value), .wr_en(wr_en), .wr_data(wr_data),
   .rd_en(rd_en), .bus_stop(bus_stop), .rd_data(rd_data), .fifo_x(fifo_x), .fifo_y(fifo_y),
   .fifo_status(fifo_status), .fifo_setup(fifo_setup), .control_one(control_one),
   .control_two(control_two), .tap_z_restart(tap_z_restart),
   .debounce_restart(debounce_restart)
);

// ===== accel_status_data_regs.v
// Accelerometer register bank: status, sample data, retention and write permission.
`timescale 1ns/1ps
`include "accel_regs.vh"
// Function
// - Retained registers keep contents when going from active to standby.
// - Status and output registers reset when going from standby to active.
// - Jolt threshold and count and X/Y tap threshold registers writable anytime (Z tap threshold only in standby); each write restarts its debounce counter.
// - Configuration writes only in standby, except active bit and soft-reset bit.
// - Address auto-increments only on burst reads; stop clears stored address.
// - Addresses 0x40 and up read zero and ignore writes.
// - Burst follows the next-address table; after 0x31 comes 0x0D.
// - FIFO mode zero shows data status at 0x00, else FIFO status.
// - Fast-read skips low data bytes; otherwise all six bytes in order.
// - Combined overwrite sets on any overwrite, clears after all three high bytes read.
// - Axis overwrite sets on new sample before read, clears on high-byte read.
// - Combined ready sets on any new sample, clears after all three high bytes read.
// - Axis ready sets on new sample, clears on high-byte read.
// - Six output registers give 14-bit two's complement samples as high/low pairs.
// - FIFO off shows current sample; FIFO on shows FIFO head.
// - Low byte read right after high byte gives the same sample.
// - Status plus three axes read in 7 bytes, 4 with fast-read.
module accel_status_data_regs #(
   parameter WIDTH = 14
) (
   // Clock and reset
   input  wire             clk,
   input  wire             srst,
   // Register access from the serial front end
   input  wire             addr_load,
   input  wire [6:0]       addr_value,
   input  wire             wr_en,
   input  wire [7:0]       wr_data,
   input  wire             rd_en,
   input  wire             bus_stop,
   output reg  [7:0]       rd_data,
   // Sample arrival from the conversion path
   input  wire             x_valid,
   input  wire             y_valid,
   input  wire             z_valid,
   input  wire [WIDTH-1:0] x_data,
   input  wire [WIDTH-1:0] y_data,
   input  wire [WIDTH-1:0] z_data,
   // FIFO head and status from the FIFO engine, and the tap source byte
   input  wire [WIDTH-1:0] fifo_x,
   input  wire [WIDTH-1:0] fifo_y,
   input  wire [WIDTH-1:0] fifo_z,
   input  wire [7:0]       fifo_status,
   input  wire [7:0]       tap_source_in,
   // Configuration outputs
   output reg  [7:0]       fifo_setup,
   output reg  [7:0]       control_one,
   output reg  [7:0]       control_two,
   output reg  [2:0]       debounce_restart,
   output reg              tap_z_restart,
   output reg              tap_config_out
);
   reg  [7:0] jolt_threshold;
   reg  [7:0] jolt_debounce;
   reg  [7:0] tap_config;
   reg  [7:0] tap_threshold_x;
   reg  [7:0] tap_threshold_y;
   reg  [7:0] tap_threshold_z;
   reg  [7:0] tap_time_limit;
   reg  [7:0] tap_latency;
   reg  [7:0] tap_window;
   reg  [7:0] sleep_counter;
   reg  [7:0] control_three;
   reg  [7:0] irq_enable;
   reg  [7:0] irq_pin_map;
   reg  [7:0] x_offset_trim;
   reg  [7:0] y_offset_trim;
   reg  [7:0] z_offset_trim;
   reg        any_axis_overwrite;
   reg        any_axis_ready;
   reg  [2:0] high_seen;
   reg        active_q;
   wire [6:0] addr;
   wire       standby;
   wire       fifo_on;
   wire       going_active;
   wire       fast_read;
   wire [2:0] high_rd;
   wire [2:0] new_sample;
   wire [WIDTH-1:0] x_sample;
   wire [WIDTH-1:0] y_sample;
   wire [WIDTH-1:0] z_sample;
   wire [WIDTH-9:0] x_low;
   wire [WIDTH-9:0] y_low;
   wire [WIDTH-9:0] z_low;
   wire       x_ready;
   wire       y_ready;
   wire       z_ready;
   wire       x_overwrite;
   wire       y_overwrite;
   wire       z_overwrite;
   reg  [WIDTH-1:0] x_head;
   reg  [WIDTH-1:0] y_head;
   reg  [WIDTH-1:0] z_head;
   reg  [7:0] next_rd_data;
   reg  [2:0] next_high_seen;

   assign standby      = ~control_one[`BIT_ACTIVE];
   assign fifo_on      = fifo_setup[`BIT_FIFO_MODE_HI] | fifo_setup[`BIT_FIFO_MODE_LO];
   assign fast_read    = control_one[`BIT_FAST_READ];
   assign going_active = control_one[`BIT_ACTIVE] & ~active_q;
   assign new_sample   = {z_valid, y_valid, x_valid} & {3{~standby}};
   assign high_rd[0]   = rd_en && (addr == `ADDR_X_HIGH);
   assign high_rd[1]   = rd_en && (addr == `ADDR_Y_HIGH);
   assign high_rd[2]   = rd_en && (addr == `ADDR_Z_HIGH);

   address_pointer u_pointer (
      .clk       (clk),
      .srst      (srst),
      .load      (addr_load),
      .load_addr (addr_value),
      .advance   (rd_en),
      .stop      (bus_stop),
      .fast_read (fast_read),
      .addr      (addr)
   );

   axis_sample #(.WIDTH(WIDTH)) u_x (
      .clk          (clk),
      .srst         (srst),
      .clear        (going_active),
      .sample_valid (new_sample[0]),
      .sample_data  (x_data),
      .high_read    (high_rd[0]),
      .low_source   (x_head[WIDTH-9:0]),
      .sample       (x_sample),
      .low_latch    (x_low),
      .ready        (x_ready),
      .overwrite    (x_overwrite)
   );

   axis_sample #(.WIDTH(WIDTH)) u_y (
      .clk          (clk),
      .srst         (srst),
      .clear        (going_active),
      .sample_valid (new_sample[1]),
      .sample_data  (y_data),
      .high_read    (high_rd[1]),
      .low_source   (y_head[WIDTH-9:0]),
      .sample       (y_sample),
      .low_latch    (y_low),
      .ready        (y_ready),
      .overwrite    (y_overwrite)
   );

   axis_sample #(.WIDTH(WIDTH)) u_z (
      .clk          (clk),
      .srst         (srst),
      .clear        (going_active),
      .sample_valid (new_sample[2]),
      .sample_data  (z_data),
      .high_read    (high_rd[2]),
      .low_source   (z_head[WIDTH-9:0]),
      .sample       (z_sample),
      .low_latch    (z_low),
      .ready        (z_ready),
      .overwrite    (z_overwrite)
   );

   // Data source follows the FIFO mode; the FIFO head low bits are latched on the high read.
   always @* begin
      x_head = fifo_on ? fifo_x : x_sample;
      y_head = fifo_on ? fifo_y : y_sample;
      z_head = fifo_on ? fifo_z : z_sample;
   end

   // Tracks which high bytes were read since the last new sample.
   always @* begin
      next_high_seen = high_seen | high_rd;
      if (|new_sample) begin
         next_high_seen = high_rd;
      end
   end

   // Read data mux.
   always @* begin
      next_rd_data = 8'h00;
      case (addr)
         `ADDR_SAMPLE_STATUS: begin
            if (fifo_on) begin
               next_rd_data = fifo_status;
            end else begin
               next_rd_data = {any_axis_overwrite, z_overwrite, y_overwrite, x_overwrite,
                               any_axis_ready, z_ready, y_ready, x_ready};
            end
         end
         `ADDR_X_HIGH:         next_rd_data = x_head[WIDTH-1:WIDTH-8];
         `ADDR_X_LOW:          next_rd_data = {x_low, 2'b00};
         `ADDR_Y_HIGH:         next_rd_data = y_head[WIDTH-1:WIDTH-8];
         `ADDR_Y_LOW:          next_rd_data = {y_low, 2'b00};
         `ADDR_Z_HIGH:         next_rd_data = z_head[WIDTH-1:WIDTH-8];
         `ADDR_Z_LOW:          next_rd_data = {z_low, 2'b00};
         `ADDR_FIFO_SETUP:     next_rd_data = fifo_setup;
         `ADDR_JOLT_THRESHOLD: next_rd_data = jolt_threshold;
         `ADDR_JOLT_DEBOUNCE:  next_rd_data = jolt_debounce;
         `ADDR_TAP_CONFIG:     next_rd_data = tap_config;
         `ADDR_TAP_SOURCE:     next_rd_data = tap_source_in;
         `ADDR_TAP_THR_X:      next_rd_data = tap_threshold_x;
         `ADDR_TAP_THR_Y:      next_rd_data = tap_threshold_y;
         `ADDR_TAP_THR_Z:      next_rd_data = tap_threshold_z;
         `ADDR_TAP_TIME_LIMIT: next_rd_data = tap_time_limit;
         `ADDR_TAP_LATENCY:    next_rd_data = tap_latency;
         `ADDR_TAP_WINDOW:     next_rd_data = tap_window;
         `ADDR_SLEEP_COUNTER:  next_rd_data = sleep_counter;
         `ADDR_CONTROL_ONE:    next_rd_data = control_one;
         `ADDR_CONTROL_TWO:    next_rd_data = control_two;
         `ADDR_CONTROL_THREE:  next_rd_data = control_three;
         `ADDR_IRQ_ENABLE:     next_rd_data = irq_enable;
         `ADDR_IRQ_PIN_MAP:    next_rd_data = irq_pin_map;
         `ADDR_X_OFFSET:       next_rd_data = x_offset_trim;
         `ADDR_Y_OFFSET:       next_rd_data = y_offset_trim;
         `ADDR_Z_OFFSET:       next_rd_data = z_offset_trim;
         default:              next_rd_data = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         rd_data            <= 8'h00;
         active_q           <= 1'b0;
         any_axis_overwrite <= 1'b0;
         any_axis_ready     <= 1'b0;
         high_seen          <= 3'h0;
      end else begin
         if (rd_en) begin
            rd_data <= next_rd_data;
         end
         active_q <= control_one[`BIT_ACTIVE];
         if (going_active) begin
            any_axis_overwrite <= 1'b0;
            any_axis_ready     <= 1'b0;
            high_seen          <= 3'h0;
         end else begin
            high_seen <= next_high_seen;
            if (|(new_sample & {z_ready, y_ready, x_ready})) begin
               any_axis_overwrite <= 1'b1;
            end else if (&next_high_seen) begin
               any_axis_overwrite <= 1'b0;
            end
            if (|new_sample) begin
               any_axis_ready <= 1'b1;
            end else if (&next_high_seen) begin
               any_axis_ready <= 1'b0;
            end
         end
      end
   end

   // Writable registers; nothing here is touched by a mode change.
   always @(posedge clk) begin
      if (srst || (wr_en && addr == `ADDR_CONTROL_TWO && wr_data[`BIT_SOFT_RESET])) begin
         fifo_setup      <= `RESET_BYTE;
         jolt_threshold  <= `RESET_BYTE;
         jolt_debounce   <= `RESET_BYTE;
         tap_config      <= `RESET_BYTE;
         tap_threshold_x <= `RESET_BYTE;
         tap_threshold_y <= `RESET_BYTE;
         tap_threshold_z <= `RESET_BYTE;
         tap_time_limit  <= `RESET_BYTE;
         tap_latency     <= `RESET_BYTE;
         tap_window      <= `RESET_BYTE;
         sleep_counter   <= `RESET_BYTE;
         control_one     <= `RESET_BYTE;
         control_two     <= `RESET_BYTE;
         control_three   <= `RESET_BYTE;
         irq_enable      <= `RESET_BYTE;
         irq_pin_map     <= `RESET_BYTE;
         x_offset_trim   <= `RESET_BYTE;
         y_offset_trim   <= `RESET_BYTE;
         z_offset_trim   <= `RESET_BYTE;
         debounce_restart <= 3'h0;
         tap_z_restart   <= 1'b0;
         tap_config_out  <= 1'b0;
      end else begin
         debounce_restart <= 3'h0;
         tap_z_restart    <= 1'b0;
         tap_config_out   <= tap_config[0];
         if (wr_en) begin
            case (addr)
               `ADDR_JOLT_THRESHOLD: begin
                  jolt_threshold <= wr_data;
                  debounce_restart[`DEBOUNCE_JOLT] <= 1'b1;
               end
               `ADDR_JOLT_DEBOUNCE: begin
                  jolt_debounce <= wr_data;
                  debounce_restart[`DEBOUNCE_JOLT] <= 1'b1;
               end
               `ADDR_TAP_THR_X: begin
                  tap_threshold_x <= wr_data;
                  debounce_restart[`DEBOUNCE_TAP_X] <= 1'b1;
               end
               `ADDR_TAP_THR_Y: begin
                  tap_threshold_y <= wr_data;
                  debounce_restart[`DEBOUNCE_TAP_Y] <= 1'b1;
               end
               `ADDR_CONTROL_ONE: begin
                  if (standby) begin
                     control_one <= wr_data;
                  end else begin
                     control_one[`BIT_ACTIVE] <= wr_data[`BIT_ACTIVE];
                  end
               end
               `ADDR_FIFO_SETUP:     if (standby) fifo_setup <= wr_data;
               `ADDR_TAP_CONFIG:     if (standby) tap_config <= wr_data;
               `ADDR_TAP_THR_Z: begin
                  if (standby) begin
                     tap_threshold_z <= wr_data;
                     tap_z_restart   <= 1'b1;
                  end
               end
               `ADDR_TAP_TIME_LIMIT: if (standby) tap_time_limit <= wr_data;
               `ADDR_TAP_LATENCY:    if (standby) tap_latency <= wr_data;
               `ADDR_TAP_WINDOW:     if (standby) tap_window <= wr_data;
               `ADDR_SLEEP_COUNTER:  if (standby) sleep_counter <= wr_data;
               `ADDR_CONTROL_TWO:    if (standby) control_two <= wr_data;
               `ADDR_CONTROL_THREE:  if (standby) control_three <= wr_data;
               `ADDR_IRQ_ENABLE:     if (standby) irq_enable <= wr_data;
               `ADDR_IRQ_PIN_MAP:    if (standby) irq_pin_map <= wr_data;
               `ADDR_X_OFFSET:       if (standby) x_offset_trim <= wr_data;
               `ADDR_Y_OFFSET:       if (standby) y_offset_trim <= wr_data;
               `ADDR_Z_OFFSET:       if (standby) z_offset_trim <= wr_data;
               default: begin
                  tap_z_restart <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ===== address_pointer.v
// Burst address pointer with next-address table and fast-read skipping.
`timescale 1ns/1ps
`include "accel_regs.vh"
module address_pointer (
   // Clock and reset
   input  wire       clk,
   input  wire       srst,
   // Bus events
   input  wire       load,
   input  wire [6:0] load_addr,
   input  wire       advance,
   input  wire       stop,
   input  wire       fast_read,
   // Pointer
   output reg  [6:0] addr
);
   reg [6:0] next_addr;
   always @* begin
      case (addr)
         `ADDR_SAMPLE_STATUS: next_addr = `ADDR_X_HIGH;
         `ADDR_X_HIGH:        next_addr = fast_read ? `ADDR_Y_HIGH : `ADDR_X_LOW;
         `ADDR_Y_HIGH:        next_addr = fast_read ? `ADDR_Z_HIGH : `ADDR_Y_LOW;
         `ADDR_Z_HIGH:        next_addr = fast_read ? `ADDR_SAMPLE_STATUS : `ADDR_Z_LOW;
         `ADDR_Z_LOW:         next_addr = `ADDR_SAMPLE_STATUS;
         `ADDR_Z_OFFSET:      next_addr = `ADDR_ID_LINK;
         default:             next_addr = addr + 7'h01;
      endcase
   end
   always @(posedge clk) begin
      if (srst || stop) begin
         addr <= 7'h00;
      end else if (load) begin
         addr <= load_addr;
      end else if (advance) begin
         addr <= next_addr;
      end
   end
endmodule

// ===== axis_sample.v
// One axis: sample capture, high-byte read latch, ready and overwrite flags.
`timescale 1ns/1ps
module axis_sample #(
   parameter WIDTH = 14
) (
   // Clock and reset
   input  wire             clk,
   input  wire             srst,
   input  wire             clear,
   // Sample arrival
   input  wire             sample_valid,
   input  wire [WIDTH-1:0] sample_data,
   // High-byte read strobe and the low bits it freezes
   input  wire             high_read,
   input  wire [WIDTH-9:0] low_source,
   // State
   output reg  [WIDTH-1:0] sample,
   output reg  [WIDTH-9:0] low_latch,
   output reg              ready,
   output reg              overwrite
);
   always @(posedge clk) begin
      if (srst || clear) begin
         sample    <= {WIDTH{1'b0}};
         low_latch <= {(WIDTH-8){1'b0}};
         ready     <= 1'b0;
         overwrite <= 1'b0;
      end else begin
         if (sample_valid) begin
            sample <= sample_data;
         end
         // Reading the high byte freezes the low bits so the pair stays one sample.
         if (high_read) begin
            low_latch <= low_source;
         end
         ready     <= sample_valid | (ready & ~high_read);
         overwrite <= (sample_valid & ready) | (overwrite & ~high_read);
      end
   end
endmodule

// ===== host_model.sv
// Host model that issues pointer loads, writes, reads and stops.
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire       clk,
   // Register access strobes
   output reg        addr_load,
   output reg  [6:0] addr_value,
   output reg        wr_en,
   output reg  [7:0] wr_data,
   output reg        rd_en,
   output reg        bus_stop
);
   initial begin
      {addr_load, wr_en, rd_en, bus_stop} = 4'h0;
      addr_value = 7'h00;
      wr_data = 8'h00;
   end

   // Kind 0 load, 1 write, 2 read, 3 stop; one taking edge then one quiet edge.
   task automatic pulse(input int k, input int a, input int d);
      begin
         addr_value = a[6:0];
         wr_data = d[7:0];
         addr_load = (k == 0);
         wr_en = (k == 1);
         rd_en = (k == 2);
         bus_stop = (k == 3);
         @(posedge clk);
         #2;
         {addr_load, wr_en, rd_en, bus_stop} = 4'h0;
         addr_value = ~a[6:0];
         wr_data = ~d[7:0];
         @(posedge clk);
         #2;
      end
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the accelerometer register bank.
`timescale 1ns/1ps
module testbench;
   reg          clk;
   reg          srst;
   reg          x_valid;
   reg          y_valid;
   reg          z_valid;
   reg   [13:0] x_data;
   reg   [13:0] y_data;
   reg   [13:0] z_data;
   reg   [13:0] fifo_x;
   reg   [13:0] fifo_y;
   reg   [13:0] fifo_z;
   reg   [7:0]  fifo_status;
   reg   [7:0]  tap_source_in;
   wire         addr_load;
   wire  [6:0]  addr_value;
   wire         wr_en;
   wire  [7:0]  wr_data;
   wire         rd_en;
   wire         bus_stop;
   wire  [7:0]  rd_data;
   int          mem [0:127];
   int          smp [3];
   int          lat [3];
   bit   [2:0]  rdy;
   bit   [2:0]  ovw;
   bit   [2:0]  seen;
   bit          anyr;
   bit          anyo;
   int          ptr;
   int          error_cnt;
   int          check_count;
   int          a;

   host_model u_host (.clk(clk), .addr_load(addr_load), .addr_value(addr_value), .wr_en(wr_en),
      .wr_data(wr_data), .rd_en(rd_en), .bus_stop(bus_stop));

   accel_status_data_regs u_dut (.clk(clk), .srst(srst), .addr_load(addr_load), .addr_value(addr_value),
      .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .bus_stop(bus_stop), .rd_data(rd_data),
      .x_valid(x_valid), .y_valid(y_valid), .z_valid(z_valid), .x_data(x_data), .y_data(y_data),
      .z_data(z_data), .fifo_x(fifo_x), .fifo_y(fifo_y), .fifo_z(fifo_z), .fifo_status(fifo_status),
      .tap_source_in(tap_source_in), .fifo_setup(), .control_one(), .control_two(), .debounce_restart(),
      .tap_z_restart(), .tap_config_out());

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic bit fon();
      return mem[9][7:6] != 0;
   endfunction

   function automatic int src(int ax);
      return fon() ? (ax == 0 ? fifo_x : ax == 1 ? fifo_y : fifo_z) : smp[ax];
   endfunction

   function automatic int expv(int r);
      if (r == 0) return fon() ? fifo_status : {anyo, ovw, anyr, rdy};
      if (r >= 1 && r <= 6) return r % 2 ? src((r - 1) / 2) >> 6 : lat[(r - 1) / 2] << 2;
      if (r == 34) return tap_source_in;
      if (r >= 64) return 0;
      return mem[r];
   endfunction

   task automatic chk(string n, int e, logic [7:0] g);
      begin
         check_count++;
         if (g !== e[7:0]) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e[7:0], g);
         end
      end
   endtask

   task automatic ld(int r);
      begin
         ptr = r;
         u_host.pulse(0, r, 0);
      end
   endtask

   task automatic rd();
      int e;
      int ax;
      begin
         e = expv(ptr);
         u_host.pulse(2, 0, 0);
         chk("rd_data", e, rd_data);
         ax = (ptr - 1) / 2;
         if (ptr inside {1, 3, 5}) begin
            lat[ax] = src(ax) & 63;
            rdy[ax] = 0;
            ovw[ax] = 0;
            seen[ax] = 1;
            if (seen == 3'h7) {anyr, anyo} = 2'h0;
         end
         if (mem[42][1] && ptr inside {1, 3, 5}) ptr = ptr == 5 ? 0 : ptr + 2;
         else ptr = ptr == 49 ? 13 : ptr == 6 ? 0 : (ptr + 1) & 127;
      end
   endtask

   task automatic wr(int r, int d);
      begin
         ld(r);
         u_host.pulse(1, r, d);
         if (r == 42 && mem[42][0]) mem[42][0] = d[0];
         else if (r == 9 || (r >= 31 && r <= 49 && r != 34)) begin
            if (!mem[42][0] || r inside {31, 32, 35, 36}) begin
               if (r == 42 && d[0]) begin
                  {rdy, ovw, seen, anyr, anyo} = '0;
                  smp = '{0, 0, 0};
                  lat = '{0, 0, 0};
               end
               mem[r] = d;
            end
         end
      end
   endtask

   task automatic smp_in(int ax, int v);
      begin
         {x_data, y_data, z_data} = {3{v[13:0]}};
         {z_valid, y_valid, x_valid} = 3'h1 << ax;
         @(posedge clk);
         #2;
         {z_valid, y_valid, x_valid} = 3'h0;
         @(posedge clk);
         #2;
         if (mem[42][0]) begin
            if (rdy[ax]) {ovw[ax], anyo} = 2'h3;
            {rdy[ax], anyr, seen} = 5'h18;
            smp[ax] = v & 16383;
         end
      end
   endtask

   task automatic stop_test();
      begin
         $display("Checks %0d, errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask

   initial begin
      #(25 * 20000);
      error_cnt++;
      stop_test();
   end

   initial begin
      srst = 1'b1;
      {x_valid, y_valid, z_valid} = 3'h0;
      {x_data, y_data, z_data} = '0;
      void'($urandom(32'hAD53));
      {fifo_x, fifo_y, fifo_z, fifo_status, tap_source_in} = {$urandom, $urandom, $urandom};
      {rdy, ovw, seen, anyr, anyo} = '0;
      smp = '{0, 0, 0};
      lat = '{0, 0, 0};
      for (a = 0; a < 128; a++) mem[a] = 0;
      repeat (4) @(posedge clk);
      #2;
      srst = 1'b0;
      ld(31);
      repeat (19) rd();
      ld(0);
      rd();
      for (a = 31; a <= 49; a++) if (!(a inside {34, 42})) wr(a, $urandom & (a == 43 ? 191 : 255));
      ld(31);
      repeat (19) rd();
      wr(1, $urandom);
      wr(69, $urandom);
      ld(69);
      rd();
      ld(1);
      rd();
      wr(42, 2);
      for (a = 1; a < 4; a++) begin
         wr(9, a * 64);
         ld(0);
         repeat (5) rd();
         ld(1);
         repeat (2) rd();
         u_host.pulse(3, 0, 0);
         ptr = 0;
         rd();
      end
      wr(42, 0);
      ld(1);
      repeat (6) rd();
      wr(9, 0);
      wr(42, 1);
      wr(47, $urandom);
      wr(32, $urandom);
      wr(42, 255);
      ld(31);
      repeat (19) rd();
      for (a = 0; a < 3; a++) smp_in(a, $urandom);
      ld(0);
      repeat (8) rd();
      smp_in(0, $urandom);
      smp_in(0, $urandom);
      smp_in(1, $urandom);
      ld(0);
      rd();
      ld(1);
      rd();
      ld(0);
      rd();
      ld(3);
      rd();
      ld(5);
      rd();
      ld(0);
      rd();
      ld(1);
      rd();
      smp_in(0, $urandom);
      rd();
      repeat (40) begin
         if ($urandom % 2) smp_in($urandom % 3, $urandom);
         else begin
            a = $urandom % 4;
            ld(a == 0 ? 0 : a * 2 - 1);
            repeat (2) rd();
         end
      end
      wr(42, 0);
      smp_in(2, $urandom);
      ld(0);
      rd();
      ld(31);
      repeat (19) rd();
      wr(42, 1);
      ld(0);
      repeat (7) rd();
      stop_test();
   end
endmodule
